// ### shared/mog_pkg.sv
// message-object gateway/fifo control: shared constants and encodings
// assumes one clock (mclk) and a synchronous active-low reset on both ends
package mog_pkg;
    // object count and index width
    localparam int MOG_NUM_OBJ = 32;
    localparam int MOG_IDX_W = 5;
    localparam int MOG_DATA_W = 16;
    // low half field positions
    localparam int MOG_LO_SOURCE_REMOTE_REQUEST_ENABLE_BIT = 9;
    localparam int MOG_LO_FD_BIT = 13;
    localparam int MOG_LO_SDT_BIT = 14;
    localparam int MOG_LO_STT_BIT = 15;
    // high half field positions
    localparam int MOG_HI_PTR_LSB = 0;
    localparam int MOG_HI_MODE_LSB = 8;
    // mode codes
    localparam logic [2:0] MOG_MODE_STD = 3'h0;
    localparam logic [2:0] MOG_MODE_FIFO_BASE = 3'h2;
    localparam logic [2:0] MOG_MODE_FIFO_SLAVE = 3'h3;
    localparam logic [2:0] MOG_MODE_NORM_GW = 3'h4;
    localparam logic [2:0] MOG_MODE_SHARED_GW = 3'h5;
    // reset values of the flags and fields
    localparam logic MOG_RST_FLAG = 1'h0;
    localparam logic [2:0] MOG_RST_MODE = 3'h0;
    // controller register indices (word addresses)
    localparam logic [7:0] MOG_REG_SEL = 8'h00;
    localparam logic [7:0] MOG_REG_CFG_LO = 8'h01;
    localparam logic [7:0] MOG_REG_CFG_HI = 8'h02;
    localparam logic [7:0] MOG_REG_CMD = 8'h03;
    localparam logic [7:0] MOG_REG_EVT = 8'h04;
    localparam logic [7:0] MOG_REG_RD_LO = 8'h05;
    localparam logic [7:0] MOG_REG_RD_HI = 8'h06;
    localparam logic [7:0] MOG_REG_STATUS = 8'h07;
    // command register bits
    localparam int MOG_CMD_SET_VALID = 0;
    localparam int MOG_CMD_CLR_VALID = 1;
    localparam int MOG_CMD_SET_TRANSMIT_REQUEST_FLAG = 2;
    // event register bits, object index in [4:0]
    localparam int MOG_EVT_RX = 8;
    localparam int MOG_EVT_TX_START = 9;
    localparam int MOG_EVT_TX_DONE = 10;
    localparam int MOG_EVT_REMOTE = 11;
    // status register bits
    localparam int MOG_ST_VALID = 0;
    localparam int MOG_ST_TRANSMIT_REQUEST_FLAG = 1;
    localparam int MOG_ST_GW_LSB = 8;
    localparam int MOG_ST_GW_SEEN = 15;
endpackage : mog_pkg

// ### shared/mog_link_if.sv
// link between the message-object store and the node-side controller
// assumes both ends share mclk; all signals change right after its rising edge
interface mog_link_if;
    import mog_pkg::*;
    // configuration and commands, driven by the controller
    logic [MOG_IDX_W-1:0] cfg_obj;
    logic [MOG_DATA_W-1:0] cfg_data;
    logic cfg_lo_we;
    logic cfg_hi_we;
    logic cfg_ptr_we;
    logic set_valid;
    logic clr_valid;
    logic set_transmit_request_flag;
    // transfer events from the protocol side
    logic [MOG_IDX_W-1:0] ev_obj;
    logic ev_rx;
    logic ev_tx_start;
    logic ev_tx_done;
    logic ev_remote;
    // answers from the object store
    logic [MOG_DATA_W-1:0] rd_lo;
    logic [MOG_DATA_W-1:0] rd_hi;
    logic [MOG_NUM_OBJ-1:0] valid_vec;
    logic [MOG_NUM_OBJ-1:0] transmit_request_flag_vec;
    logic gw_pulse;
    logic [MOG_IDX_W-1:0] gw_obj;

    modport objects (
        input cfg_obj, cfg_data, cfg_lo_we, cfg_hi_we, cfg_ptr_we,
        input set_valid, clr_valid, set_transmit_request_flag,
        input ev_obj, ev_rx, ev_tx_start, ev_tx_done, ev_remote,
        output rd_lo, rd_hi, valid_vec, transmit_request_flag_vec, gw_pulse, gw_obj
    );
    modport ctrl (
        output cfg_obj, cfg_data, cfg_lo_we, cfg_hi_we, cfg_ptr_we,
        output set_valid, clr_valid, set_transmit_request_flag,
        output ev_obj, ev_rx, ev_tx_start, ev_tx_done, ev_remote,
        input rd_lo, rd_hi, valid_vec, transmit_request_flag_vec, gw_pulse, gw_obj
    );
endinterface : mog_link_if

// ### hw/mog_objects.sv
// message-object store: per-object mode, fifo direction, single-shot bits,
// link pointer, valid and transmit-request flags
// assumes the controller end sends one-cycle events and configuration strobes,
// and that it filters software pointer writes to running fifos before they arrive
// What this block does
// - fifo direction read only from base object
// - direction 0: pointer advances on reception only
// - direction 1: pointer advances on transmission only
// - fifo direction independent of frame direction
// - single-data bit clears valid after data transfer
// - remote frames never clear valid that way
// - software keeps single-data bit clear in fifos
// - single-try bit clears request at transmission start
// - lost or corrupted single-try frame not resent
// - standard mode without remote enable ignores pointer, holds own number
// - base pointer names next element, starts at base
// - slave pointer holds the base object number
// - normal gateway pointer names destination object
// - destination with remote enable links back to source
// - remote enable off: pointer ignored, own number
// - shared gateway ignores pointer, own number
// - software leaves fifo pointers to hardware
// - mode field selects the object role
//
// The address-and-strobe port and the address map were left to the implementer.
module mog_objects
    import mog_pkg::*;
#(
    parameter int NUM_OBJ = MOG_NUM_OBJ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // link to the controller end
    mog_link_if.objects lnk
);
    generate
        if (NUM_OBJ < 2 || NUM_OBJ > (1 << MOG_IDX_W)) begin : g_bad
            $error("mog_objects: NUM_OBJ out of range");
        end
        // field positions must fit in one half word without overlapping
        if (MOG_LO_STT_BIT >= MOG_DATA_W || MOG_HI_MODE_LSB + 3 > MOG_DATA_W ||
            MOG_HI_PTR_LSB + MOG_IDX_W > MOG_HI_MODE_LSB) begin : g_bad_fields
            $error("mog_objects: field layout does not fit");
        end
    endgenerate

    // per-object configuration
    logic [2:0] mode [NUM_OBJ];
    logic [MOG_IDX_W-1:0] ptr [NUM_OBJ];
    logic [NUM_OBJ-1:0] fd;
    logic [NUM_OBJ-1:0] single_data_transfer_bit;
    logic [NUM_OBJ-1:0] single_transmit_try_bit;
    logic [NUM_OBJ-1:0] source_remote_request_enable;
    // per-object flags, set by software and cleared by transfers
    logic [NUM_OBJ-1:0] valid;
    logic [NUM_OBJ-1:0] transmit_request_flag;
    // decode of the current transfer event
    logic [MOG_IDX_W-1:0] ev_base;
    logic ev_in_fifo;
    logic advance;
    logic [MOG_IDX_W-1:0] next_ptr;

    // an object takes part in a fifo only as base or slave;
    // reserved mode codes are neither, so they never move a pointer
    function automatic logic is_fifo(input logic [2:0] m);
        return (m == MOG_MODE_FIFO_BASE) || (m == MOG_MODE_FIFO_SLAVE);
    endfunction

    // fifo base of the event object: itself, or the one its pointer names;
    // a slave with a wrong pointer steers its events to the wrong base
    always_comb begin
        ev_in_fifo = is_fifo(mode[lnk.ev_obj]);
        ev_base = (mode[lnk.ev_obj] == MOG_MODE_FIFO_BASE) ? lnk.ev_obj : ptr[lnk.ev_obj];
    end

    // advance only for the element that the base currently addresses;
    // the direction bit comes from the base, never from the element
    always_comb begin
        advance = ev_in_fifo && (lnk.ev_obj == ptr[ev_base]) &&
                  ((lnk.ev_rx && !fd[ev_base]) ||
                   (lnk.ev_tx_done && fd[ev_base]));
    end

    // next element: following object if it is a slave of this base, else wrap;
    // with no size field a fifo ends at the first object that is not its slave,
    // so slaves must sit at consecutive numbers right after the base
    always_comb begin
        next_ptr = ev_base;
        if ((32'(lnk.ev_obj) + 32'd1) < 32'(NUM_OBJ)) begin
            if (mode[lnk.ev_obj + 1'b1] == MOG_MODE_FIFO_SLAVE &&
                ptr[lnk.ev_obj + 1'b1] == ev_base) begin
                next_ptr = lnk.ev_obj + 1'b1;
            end
        end
    end

    // configuration fields; pointer holds own number from reset
    // the pointer is written only when the controller lets the write through
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                mode[i] <= MOG_RST_MODE;
                ptr[i] <= MOG_IDX_W'(i);
            end
            fd <= '0;
            single_data_transfer_bit <= '0;
            single_transmit_try_bit <= '0;
            source_remote_request_enable <= '0;
        end else begin
            if (lnk.cfg_lo_we) begin
                source_remote_request_enable[lnk.cfg_obj] <= lnk.cfg_data[MOG_LO_SOURCE_REMOTE_REQUEST_ENABLE_BIT];
                fd[lnk.cfg_obj] <= lnk.cfg_data[MOG_LO_FD_BIT];
                single_data_transfer_bit[lnk.cfg_obj] <= lnk.cfg_data[MOG_LO_SDT_BIT];
                single_transmit_try_bit[lnk.cfg_obj] <= lnk.cfg_data[MOG_LO_STT_BIT];
            end
            if (lnk.cfg_hi_we) begin
                mode[lnk.cfg_obj] <= lnk.cfg_data[MOG_HI_MODE_LSB +: 3];
            end
            if (lnk.cfg_hi_we && lnk.cfg_ptr_we) begin
                ptr[lnk.cfg_obj] <= lnk.cfg_data[MOG_HI_PTR_LSB +: MOG_IDX_W];
            end
            // hardware advance wins over a software pointer write
            if (advance) begin
                ptr[ev_base] <= next_ptr;
            end
        end
    end

    // valid flag: software set wins over the automatic clear
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            valid <= '0;
        end else begin
            if (lnk.clr_valid) begin
                valid[lnk.cfg_obj] <= 1'b0;
            end
            // a remote frame leaves the flag alone whatever the single-data bit says
            if ((lnk.ev_rx || lnk.ev_tx_done) && !lnk.ev_remote && single_data_transfer_bit[lnk.ev_obj]) begin
                valid[lnk.ev_obj] <= 1'b0;
            end
            if (lnk.set_valid) begin
                valid[lnk.cfg_obj] <= 1'b1;
            end
        end
    end

    // transmit request: dropped at start when single-try, so a lost or
    // corrupted frame is never retried; a completed send also drops it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            transmit_request_flag <= '0;
        end else begin
            if (lnk.ev_tx_start && single_transmit_try_bit[lnk.ev_obj]) begin
                transmit_request_flag[lnk.ev_obj] <= 1'b0;
            end
            if (lnk.ev_tx_done) begin
                transmit_request_flag[lnk.ev_obj] <= 1'b0;
            end
            if (lnk.set_transmit_request_flag) begin
                transmit_request_flag[lnk.cfg_obj] <= 1'b1;
            end
        end
    end

    // gateway hand-off: forward data to destination, remote back to source
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lnk.gw_pulse <= 1'b0;
            lnk.gw_obj <= '0;
        end else begin
            lnk.gw_pulse <= 1'b0;
            // gw_obj holds the last target so it can be read back after the pulse
            if (lnk.ev_rx && !lnk.ev_remote && mode[lnk.ev_obj] == MOG_MODE_NORM_GW) begin
                lnk.gw_pulse <= 1'b1;
                lnk.gw_obj <= ptr[lnk.ev_obj];
            end
            // shared gateway and standard objects without remote enable ignore ptr
            if (lnk.ev_rx && lnk.ev_remote && mode[lnk.ev_obj] == MOG_MODE_STD &&
                source_remote_request_enable[lnk.ev_obj]) begin
                lnk.gw_pulse <= 1'b1;
                lnk.gw_obj <= ptr[lnk.ev_obj];
            end
        end
    end

    // readback of the selected object, reserved bits zero
    // readback lags cfg_obj by one cycle; the controller polices writes on it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lnk.rd_lo <= '0;
            lnk.rd_hi <= '0;
        end else begin
            lnk.rd_lo <= '0;
            lnk.rd_lo[MOG_LO_SOURCE_REMOTE_REQUEST_ENABLE_BIT] <= source_remote_request_enable[lnk.cfg_obj];
            lnk.rd_lo[MOG_LO_FD_BIT] <= fd[lnk.cfg_obj];
            lnk.rd_lo[MOG_LO_SDT_BIT] <= single_data_transfer_bit[lnk.cfg_obj];
            lnk.rd_lo[MOG_LO_STT_BIT] <= single_transmit_try_bit[lnk.cfg_obj];
            lnk.rd_hi <= '0;
            lnk.rd_hi[MOG_HI_MODE_LSB +: 3] <= mode[lnk.cfg_obj];
            lnk.rd_hi[MOG_HI_PTR_LSB +: MOG_IDX_W] <= ptr[lnk.cfg_obj];
        end
    end

    // flag vectors, padded when fewer objects are built
    // unused upper bits read as zero rather than as stale values
    always_comb begin
        lnk.valid_vec = '0;
        lnk.transmit_request_flag_vec = '0;
        lnk.valid_vec[NUM_OBJ-1:0] = valid;
        lnk.transmit_request_flag_vec[NUM_OBJ-1:0] = transmit_request_flag;
    end
endmodule // mog_objects

// ### hw/mog_ctrl.sv
// node-side controller: software register port, configuration policing,
// command and event strobes toward the object store
// assumes software waits two cycles after a select write before relying on it
module mog_ctrl
    import mog_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // software register port
    input wire logic [7:0] addr,
    input wire logic [MOG_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [MOG_DATA_W-1:0] rdata,
    // link to the object store
    mog_link_if.ctrl lnk
);
    logic [2:0] cur_mode;
    logic [2:0] new_mode;
    logic gw_seen;
    logic [MOG_IDX_W-1:0] gw_last;
    logic [MOG_DATA_W-1:0] next_cfg;
    logic next_ptr_we;

    always_comb begin
        cur_mode = lnk.rd_hi[MOG_HI_MODE_LSB +: 3];
        new_mode = wdata[MOG_HI_MODE_LSB +: 3];
    end

    // police configuration writes before they reach the store
    always_comb begin
        next_cfg = wdata;
        next_ptr_we = 1'b1;
        if (addr == MOG_REG_CFG_LO &&
            (cur_mode == MOG_MODE_FIFO_BASE || cur_mode == MOG_MODE_FIFO_SLAVE)) begin
            next_cfg[MOG_LO_SDT_BIT] = 1'b0;
        end
        if (addr == MOG_REG_CFG_HI) begin
            // roles whose pointer is unused, and a new base, take own number
            if (new_mode == MOG_MODE_SHARED_GW || new_mode == MOG_MODE_FIFO_BASE ||
                (new_mode == MOG_MODE_STD && !lnk.rd_lo[MOG_LO_SOURCE_REMOTE_REQUEST_ENABLE_BIT])) begin
                next_cfg[MOG_HI_PTR_LSB +: MOG_IDX_W] = lnk.cfg_obj;
            end
            // a running fifo keeps the pointer the hardware maintains
            if ((cur_mode == MOG_MODE_FIFO_BASE || cur_mode == MOG_MODE_FIFO_SLAVE) &&
                (new_mode == MOG_MODE_FIFO_BASE || new_mode == MOG_MODE_FIFO_SLAVE)) begin
                next_ptr_we = 1'b0;
            end
        end
    end

    // object select and configuration strobes, one cycle after the write
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lnk.cfg_obj <= '0;
            lnk.cfg_data <= '0;
            lnk.cfg_lo_we <= 1'b0;
            lnk.cfg_hi_we <= 1'b0;
            lnk.cfg_ptr_we <= 1'b0;
            lnk.set_valid <= 1'b0;
            lnk.clr_valid <= 1'b0;
            lnk.set_transmit_request_flag <= 1'b0;
        end else begin
            lnk.cfg_lo_we <= wr && addr == MOG_REG_CFG_LO;
            lnk.cfg_hi_we <= wr && addr == MOG_REG_CFG_HI;
            lnk.cfg_ptr_we <= next_ptr_we;
            lnk.set_valid <= wr && addr == MOG_REG_CMD && wdata[MOG_CMD_SET_VALID];
            lnk.clr_valid <= wr && addr == MOG_REG_CMD && wdata[MOG_CMD_CLR_VALID];
            lnk.set_transmit_request_flag <= wr && addr == MOG_REG_CMD && wdata[MOG_CMD_SET_TRANSMIT_REQUEST_FLAG];
            if (wr) begin
                lnk.cfg_data <= next_cfg;
            end
            if (wr && addr == MOG_REG_SEL) begin
                lnk.cfg_obj <= wdata[MOG_IDX_W-1:0];
            end
        end
    end

    // protocol events, stood in for by software, one cycle long
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lnk.ev_obj <= '0;
            lnk.ev_rx <= 1'b0;
            lnk.ev_tx_start <= 1'b0;
            lnk.ev_tx_done <= 1'b0;
            lnk.ev_remote <= 1'b0;
        end else begin
            lnk.ev_rx <= wr && addr == MOG_REG_EVT && wdata[MOG_EVT_RX];
            lnk.ev_tx_start <= wr && addr == MOG_REG_EVT && wdata[MOG_EVT_TX_START];
            lnk.ev_tx_done <= wr && addr == MOG_REG_EVT && wdata[MOG_EVT_TX_DONE];
            if (wr && addr == MOG_REG_EVT) begin
                lnk.ev_obj <= wdata[MOG_IDX_W-1:0];
                lnk.ev_remote <= wdata[MOG_EVT_REMOTE];
            end
        end
    end

    // sticky gateway flag: a new hand-off wins over the read that clears it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gw_seen <= 1'b0;
            gw_last <= '0;
        end else begin
            if (rd && addr == MOG_REG_STATUS) begin
                gw_seen <= 1'b0;
            end
            if (lnk.gw_pulse) begin
                gw_seen <= 1'b1;
                gw_last <= lnk.gw_obj;
            end
        end
    end

    // read data in the cycle after the strobe, unmapped reads as zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= '0;
            if (rd) begin
                unique case (addr)
                    MOG_REG_SEL: rdata[MOG_IDX_W-1:0] <= lnk.cfg_obj;
                    MOG_REG_RD_LO: rdata <= lnk.rd_lo;
                    MOG_REG_RD_HI: rdata <= lnk.rd_hi;
                    MOG_REG_STATUS: begin
                        rdata[MOG_ST_VALID] <= lnk.valid_vec[lnk.cfg_obj];
                        rdata[MOG_ST_TRANSMIT_REQUEST_FLAG] <= lnk.transmit_request_flag_vec[lnk.cfg_obj];
                        rdata[MOG_ST_GW_LSB +: MOG_IDX_W] <= gw_last;
                        rdata[MOG_ST_GW_SEEN] <= gw_seen;
                    end
                    default: rdata <= '0;
                endcase
            end
        end
    end
endmodule // mog_ctrl

// ### testbench/mog_monitor.sv
// checker for the link between the object store and the controller
// assumes events are fired with cfg_obj already selected on the same object
module mog_monitor
    import mog_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // link signals
    input wire logic [MOG_IDX_W-1:0] cfg_obj,
    input wire logic [MOG_IDX_W-1:0] ev_obj,
    input wire logic ev_rx,
    input wire logic ev_tx_start,
    input wire logic ev_tx_done,
    input wire logic ev_remote,
    input wire logic [MOG_DATA_W-1:0] rd_lo,
    input wire logic [MOG_DATA_W-1:0] rd_hi,
    input wire logic [MOG_NUM_OBJ-1:0] valid_vec,
    input wire logic [MOG_NUM_OBJ-1:0] transmit_request_flag_vec,
    input wire logic gw_pulse,
    input wire logic [MOG_IDX_W-1:0] gw_obj
);
    timeunit 1ns;
    timeprecision 1ns;
    // readback is trusted only once cfg_obj has settled on the event object
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire hit = cfg_obj == ev_obj;

    sdt_clear_a: assert property ((ev_rx || ev_tx_done) && !ev_remote && hit && rd_lo[14]
        && $stable(cfg_obj) |=> !valid_vec[$past(ev_obj)]) else $error("valid kept");
    sdt_keep_a: assert property ((ev_rx || ev_tx_done) && hit && !rd_lo[14]
        && $stable(cfg_obj) && valid_vec[ev_obj] |=> valid_vec[$past(ev_obj)])
        else $error("valid lost");
    remote_keep_a: assert property ((ev_rx || ev_tx_done) && ev_remote
        && valid_vec[ev_obj] |=> valid_vec[$past(ev_obj)]) else $error("remote cleared valid");
    stt_clear_a: assert property (ev_tx_start && hit && rd_lo[15] && $stable(cfg_obj)
        |=> !transmit_request_flag_vec[$past(ev_obj)]) else $error("request kept at start");
    stt_keep_a: assert property (ev_tx_start && hit && !rd_lo[15] && transmit_request_flag_vec[ev_obj]
        && $stable(cfg_obj) |=> transmit_request_flag_vec[$past(ev_obj)]) else $error("request lost at start");
    gw_norm_a: assert property (ev_rx && !ev_remote && hit && rd_hi[10:8] == 3'h4
        && $stable(cfg_obj) |=> gw_pulse && gw_obj == $past(rd_hi[4:0]))
        else $error("gateway destination wrong");
    gw_back_a: assert property (ev_rx && ev_remote && hit && rd_hi[10:8] == 3'h0
        && rd_lo[9] && $stable(cfg_obj) |=> gw_pulse && gw_obj == $past(rd_hi[4:0]))
        else $error("backward link wrong");
    gw_none_a: assert property (ev_rx && hit && $stable(cfg_obj) && (rd_hi[10:8] == 3'h5
        || (rd_hi[10:8] == 3'h0 && !rd_lo[9])) |=> !gw_pulse) else $error("pointer used");
    fifo_hold_a: assert property (hit && $stable(cfg_obj) && rd_hi[10:8] == 3'h2
        && ((ev_tx_done && !rd_lo[13]) || (ev_rx && rd_lo[13]))
        |-> ##2 rd_hi[4:0] == $past(rd_hi[4:0], 2)) else $error("fifo pointer moved");
endmodule // mog_monitor

// ### testbench/testbench.sv
// self-checking bench: controller and object store joined by the link
// assumes a reference model of all 32 objects kept in plain arrays
module testbench import mog_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b, wr, rd;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    int miscompares, n_checks, cycles, r;
    int m_ptr[32], m_mode[32], gw_last;
    bit m_fd[32], m_sdt[32], m_stt[32], m_srr[32], m_val[32], m_txq[32], gw_seen;
    mog_link_if lnk();
    mog_ctrl mog_ctrl_i (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .lnk(lnk.ctrl));
    mog_objects mog_objects_i (.mclk(mclk), .rst_b(rst_b), .lnk(lnk.objects));
    mog_monitor mog_monitor_i (.mclk(mclk), .rst_b(rst_b), .cfg_obj(lnk.cfg_obj),
        .ev_obj(lnk.ev_obj), .ev_rx(lnk.ev_rx), .ev_tx_start(lnk.ev_tx_start),
        .ev_tx_done(lnk.ev_tx_done), .ev_remote(lnk.ev_remote), .rd_lo(lnk.rd_lo),
        .rd_hi(lnk.rd_hi), .valid_vec(lnk.valid_vec), .transmit_request_flag_vec(lnk.transmit_request_flag_vec),
        .gw_pulse(lnk.gw_pulse), .gw_obj(lnk.gw_obj));

    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // software port: one-cycle strobes, read data taken in the cycle after
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask
    // readback lags the select by a cycle, so wait before relying on it
    task automatic sel(input int o);
        wreg(MOG_REG_SEL, 16'(o));
        repeat (2) @(posedge mclk);
    endtask
    function automatic bit isf(input int md);
        return md == 2 || md == 3;
    endfunction
    task automatic cfg_lo(input int o, input bit srr, input bit fd, input bit single_data_transfer_bit, input bit single_transmit_try_bit);
        logic [15:0] d;
        d = 16'h0;
        d[MOG_LO_SOURCE_REMOTE_REQUEST_ENABLE_BIT] = srr;
        d[MOG_LO_FD_BIT] = fd;
        d[MOG_LO_SDT_BIT] = single_data_transfer_bit;
        d[MOG_LO_STT_BIT] = single_transmit_try_bit;
        sel(o);
        wreg(MOG_REG_CFG_LO, d);
        m_srr[o] = srr;
        m_fd[o] = fd;
        m_stt[o] = single_transmit_try_bit;
        m_sdt[o] = isf(m_mode[o]) ? 1'b0 : single_data_transfer_bit;
    endtask
    task automatic cfg_hi(input int o, input int md, input int p);
        sel(o);
        wreg(MOG_REG_CFG_HI, {5'h0, 3'(md), 3'h0, 5'(p)});
        if (!(isf(m_mode[o]) && isf(md)))
            m_ptr[o] = (md == 2 || md == 5 || (md == 0 && !m_srr[o])) ? o : p;
        m_mode[o] = md;
    endtask
    task automatic cmd(input int o, input int b);
        sel(o);
        wreg(MOG_REG_CMD, 16'h1 << b);
        if (b != MOG_CMD_SET_TRANSMIT_REQUEST_FLAG) m_val[o] = (b == MOG_CMD_SET_VALID);
        if (b == MOG_CMD_SET_TRANSMIT_REQUEST_FLAG) m_txq[o] = 1'b1;
    endtask
    // fire one transfer event and advance the model the same way
    task automatic evt(input int o, input int k, input bit rem);
        logic [15:0] d;
        int b, n;
        d = 16'(o);
        d[k] = 1'b1;
        d[MOG_EVT_REMOTE] = rem;
        sel(o);
        wreg(MOG_REG_EVT, d);
        repeat (3) @(posedge mclk);
        if (isf(m_mode[o])) begin
            b = (m_mode[o] == 2) ? o : m_ptr[o];
            if (o == m_ptr[b] && ((k == MOG_EVT_RX && !m_fd[b]) ||
                (k == MOG_EVT_TX_DONE && m_fd[b]))) begin
                n = o + 1;
                m_ptr[b] = (n < 32 && m_mode[n] == 3 && m_ptr[n] == b) ? n : b;
            end
        end
        if (k != MOG_EVT_TX_START && !rem && m_sdt[o]) m_val[o] = 1'b0;
        if ((k == MOG_EVT_TX_START && m_stt[o]) || k == MOG_EVT_TX_DONE) m_txq[o] = 1'b0;
        if (k == MOG_EVT_RX && ((!rem && m_mode[o] == 4) ||
            (rem && m_mode[o] == 0 && m_srr[o]))) begin
            gw_last = m_ptr[o];
            gw_seen = 1'b1;
        end
    endtask
    task automatic chk(input int o);
        logic [15:0] v;
        sel(o);
        rreg(MOG_REG_RD_HI, v);
        check("pointer and mode", v, {5'h0, 3'(m_mode[o]), 3'h0, 5'(m_ptr[o])});
        rreg(MOG_REG_RD_LO, v);
        check("config low", v, {m_stt[o], m_sdt[o], m_fd[o], 3'h0, m_srr[o], 9'h0});
        rreg(MOG_REG_STATUS, v);
        check("status", v, {gw_seen, 2'h0, 5'(gw_last), 6'h0, m_txq[o], m_val[o]});
        gw_seen = 1'b0;
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        for (int i = 0; i < 32; i++) m_ptr[i] = i;
        void'($urandom(30));
        r = 24 + ($urandom % 4);
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk(r);
        // fifo of three elements, reception side; slave 6 wraps back to base
        cfg_hi(4, 2, 0);
        cfg_hi(5, 3, 4);
        cfg_hi(6, 3, 4);
        cfg_lo(5, 0, 0, 1, 0);
        evt(5, MOG_EVT_RX, 0); chk(4);
        evt(4, MOG_EVT_TX_DONE, 0); chk(4);
        evt(4, MOG_EVT_RX, 0); chk(4);
        evt(5, MOG_EVT_RX, 1); chk(4);
        evt(6, MOG_EVT_RX, 0); chk(4);
        // transmission side: direction set in the base only
        cfg_lo(4, 0, 1, 0, 0);
        evt(4, MOG_EVT_RX, 0); chk(4);
        evt(4, MOG_EVT_TX_DONE, 0); chk(4);
        evt(5, MOG_EVT_TX_DONE, 0); chk(4);
        cfg_hi(4, 2, 9); chk(4);
        // single data transfer
        cfg_lo(r, 0, 0, 1, 0);
        cmd(r, MOG_CMD_SET_VALID);
        evt(r, MOG_EVT_RX, 1); chk(r);
        evt(r, MOG_EVT_TX_DONE, 0); chk(r);
        cfg_lo(r, 0, 1, 0, 0);
        cmd(r, MOG_CMD_SET_VALID);
        evt(r, MOG_EVT_RX, 0); chk(r);
        cmd(r, MOG_CMD_CLR_VALID); chk(r);
        // single transmission try
        cfg_lo(r + 4, 0, 0, 0, 1);
        cmd(r + 4, MOG_CMD_SET_TRANSMIT_REQUEST_FLAG);
        evt(r + 4, MOG_EVT_TX_START, 0); chk(r + 4);
        cfg_lo(r + 4, 0, 0, 0, 0);
        cmd(r + 4, MOG_CMD_SET_TRANSMIT_REQUEST_FLAG);
        evt(r + 4, MOG_EVT_TX_START, 0); chk(r + 4);
        // gateways and other pointer roles
        cfg_hi(12, 4, 20);
        evt(12, MOG_EVT_RX, 0); chk(12);
        cfg_lo(13, 1, 0, 0, 0);
        cfg_hi(13, 0, 7);
        evt(13, MOG_EVT_RX, 1); chk(13);
        cfg_hi(14, 0, 9);
        evt(14, MOG_EVT_RX, 1); chk(14);
        cfg_hi(15, 5, 3);
        evt(15, MOG_EVT_RX, 0); chk(15);
        cfg_hi(16, 7, 3);
        evt(16, MOG_EVT_RX, 0); chk(16);
        stop_test();
    end
endmodule // testbench
